//--- rtl/mac_map.svh
`ifndef MAC_MAP_SVH
`define MAC_MAP_SVH
`define MAC_OFS_AUX_PIN       8'h12
`define MAC_OFS_SEL_A         8'h13
`define MAC_OFS_SEL_B         8'h14
`define MAC_OFS_FAULT_EN      8'h15
`define MAC_OFS_LIM_A         8'h16
`define MAC_OFS_LIM_B         8'h17
`define MAC_OFS_LIM_C         8'h18
`define MAC_RST_AUX_PIN       8'hf0
`define MAC_RST_SEL_A         8'hff
`define MAC_RST_SEL_B         8'h0f
`define MAC_RST_FAULT_EN      8'h00
`define MAC_RST_LIM           8'h00
`define MAC_BIT_EN_CHANGED    7
`define MAC_BIT_MEM_WRITTEN   6
`endif

//--- rtl/mac_pkg.sv
package mac_pkg;
   typedef logic [7:0] mac_byte_t;
endpackage : mac_pkg

//--- rtl/mac_regs.sv
// Functional notes
// RULE_01: Bits 7:4 set aux pin direction, reset input.
// RULE_02: Bits 3:0 give aux output levels, reset zero.
// RULE_03: Select A picks single-ended inputs, reset ones.
// RULE_04: Select B 7:4 picks differential pairs, reset zero.
// RULE_05: Select B 3:0 picks sense and drain, reset one.
// RULE_06: Fault enable register gates eight fault alerts.
// RULE_07: Limit A bit 7 alerts on enable pin change.
// RULE_08: Limit A bit 6 alerts on memory write.
// RULE_09: Limit A bits 5:4 gate current limits.
// RULE_10: Limit A bits 3:2 gate supply limits.
// RULE_11: Limit A bits 1:0 gate power limits.
// RULE_12: Limit B gates analog input limit pairs.
// RULE_13: Limit C gates aux pin limit pairs.
// RULE_14: Enabled alert latches flag until host clears.
// RULE_15: Limit events count only after selected conversion.
// RULE_16: Enables gate alerts, never alter status.
`include "mac_map.svh"
`timescale 1ns/1ps
`default_nettype none
module mac_regs (
   input  wire logic       clk,
   input  wire logic       sys_rst,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   output logic [7:0]      reg_rdata,
   output logic            reg_rvalid,
   input  wire logic       alert_clear,
   input  wire logic [3:0] aux_io_pin_in,
   output logic [3:0]      aux_io_pin_out,
   output logic [3:0]      aux_io_pin_oe_n,
   output logic [7:0]      sel_single_ended,
   output logic [7:0]      sel_pair_sense,
   input  wire logic [7:0] fault_event,
   input  wire logic       enable_pin_changed,
   input  wire logic       nvm_written,
   input  wire logic       conv_done,
   input  wire logic [3:0] conv_channel,
   input  wire logic       conv_high,
   input  wire logic       conv_low,
   output logic            alert_generated
);
   mac_pkg::mac_byte_t aux_pin, sel_a, sel_b, fault_en, lim_a, lim_b, lim_c;
   mac_pkg::mac_byte_t next_aux_pin, next_sel_a, next_sel_b, next_fault_en;
   mac_pkg::mac_byte_t next_lim_a, next_lim_b, next_lim_c, next_rdata;
   logic               next_rvalid, next_alert, hit;
   logic [3:0]         next_pin_out, next_oe_n;

   // Channel codes: 0-3 analog inputs, 4-7 aux pins, 8 current, 9 supply, 10 power.
   function automatic logic [1:0] lim_pair(input logic [7:0] r, input logic [1:0] i);
      lim_pair = {r[7 - 2 * i], r[6 - 2 * i]};
   endfunction : lim_pair

   function automatic logic limit_hit(input logic [3:0] ch, input logic hi, input logic lo,
                                      input mac_pkg::mac_byte_t sa, input mac_pkg::mac_byte_t sb,
                                      input mac_pkg::mac_byte_t la, input mac_pkg::mac_byte_t lb,
                                      input mac_pkg::mac_byte_t lc);
      logic [1:0] en;
      logic       sel;
      en  = 2'b00;
      sel = 1'b0;
      if (ch < 4'h4) begin
         en  = lim_pair(lb, ch[1:0]);                                     // [RULE_12]
         sel = sa[ch[1:0]];                                               // [RULE_03]
      end else if (ch < 4'h8) begin
         en  = lim_pair(lc, ch[1:0]);                                     // [RULE_13]
         sel = sa[4 + ch[1:0]];
      end else if (ch == 4'h8) begin
         en  = la[5:4];                                                   // [RULE_09]
         sel = sb[2] | sb[3];                                             // [RULE_05]
      end else if (ch == 4'h9) begin
         en  = la[3:2];                                                   // [RULE_10]
         sel = 1'b1;
      end else if (ch == 4'ha) begin
         en  = la[1:0];                                                   // [RULE_11]
         sel = 1'b1;
      end
      limit_hit = sel & ((en[1] & hi) | (en[0] & lo));                    // [RULE_15] [RULE_16]
   endfunction : limit_hit

   always_comb begin
      next_aux_pin  = aux_pin;
      next_sel_a    = sel_a;
      next_sel_b    = sel_b;
      next_fault_en = fault_en;
      next_lim_a    = lim_a;
      next_lim_b    = lim_b;
      next_lim_c    = lim_c;
      if (reg_wr) begin
         unique case (reg_addr)
            `MAC_OFS_AUX_PIN:  next_aux_pin  = reg_wdata;
            `MAC_OFS_SEL_A:    next_sel_a    = reg_wdata;
            `MAC_OFS_SEL_B:    next_sel_b    = reg_wdata;
            `MAC_OFS_FAULT_EN: next_fault_en = reg_wdata;
            `MAC_OFS_LIM_A:    next_lim_a    = reg_wdata;
            `MAC_OFS_LIM_B:    next_lim_b    = reg_wdata;
            `MAC_OFS_LIM_C:    next_lim_c    = reg_wdata;
            default: ;
         endcase
      end
      next_rvalid = reg_rd;
      next_rdata  = reg_rdata;
      if (reg_rd) begin
         unique case (reg_addr)
            `MAC_OFS_AUX_PIN:  next_rdata = aux_pin;
            `MAC_OFS_SEL_A:    next_rdata = sel_a;
            `MAC_OFS_SEL_B:    next_rdata = sel_b;
            `MAC_OFS_FAULT_EN: next_rdata = fault_en;
            `MAC_OFS_LIM_A:    next_rdata = lim_a;
            `MAC_OFS_LIM_B:    next_rdata = lim_b;
            `MAC_OFS_LIM_C:    next_rdata = lim_c;
            default:           next_rdata = 8'h00;
         endcase
      end
      // A direction bit of one releases the pin; a zero drives the stored level.
      next_oe_n    = next_aux_pin[7:4];                                   // [RULE_01]
      next_pin_out = next_aux_pin[3:0] & ~next_aux_pin[7:4];              // [RULE_02]
      hit = (|(fault_event & fault_en))                                   // [RULE_06] [RULE_16]
          | (enable_pin_changed & lim_a[`MAC_BIT_EN_CHANGED])             // [RULE_07]
          | (nvm_written & lim_a[`MAC_BIT_MEM_WRITTEN])                   // [RULE_08]
          | (conv_done & limit_hit(conv_channel, conv_high, conv_low, sel_a, sel_b, lim_a, lim_b, lim_c));
      // A new alert in the clearing cycle wins over the clear.
      next_alert = hit | (alert_generated & ~alert_clear);                // [RULE_14]
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         aux_pin         <= `MAC_RST_AUX_PIN;
         sel_a           <= `MAC_RST_SEL_A;
         sel_b           <= `MAC_RST_SEL_B;                               // [RULE_04] [RULE_05]
         fault_en        <= `MAC_RST_FAULT_EN;
         lim_a           <= `MAC_RST_LIM;
         lim_b           <= `MAC_RST_LIM;
         lim_c           <= `MAC_RST_LIM;
         reg_rdata       <= 8'h00;
         reg_rvalid      <= 1'b0;
         aux_io_pin_out  <= 4'h0;
         aux_io_pin_oe_n <= 4'hf;
         sel_single_ended <= `MAC_RST_SEL_A;
         sel_pair_sense  <= `MAC_RST_SEL_B;
         alert_generated <= 1'b0;
      end else begin
         aux_pin         <= next_aux_pin;
         sel_a           <= next_sel_a;
         sel_b           <= next_sel_b;
         fault_en        <= next_fault_en;
         lim_a           <= next_lim_a;
         lim_b           <= next_lim_b;
         lim_c           <= next_lim_c;
         reg_rdata       <= next_rdata;
         reg_rvalid      <= next_rvalid;
         aux_io_pin_out  <= next_pin_out;
         aux_io_pin_oe_n <= next_oe_n;
         sel_single_ended <= next_sel_a;                                  // [RULE_03]
         sel_pair_sense  <= next_sel_b;                                   // [RULE_04]
         alert_generated <= next_alert;
      end
   end
endmodule : mac_regs
`default_nettype wire

//--- verification/mac_src.sv
`timescale 1ns/1ps
`default_nettype none
module mac_src (
   input  wire logic       fire,
   input  wire logic [5:0] code,
   output logic [7:0]      fault_event,
   output logic            enable_pin_changed, nvm_written, conv_done, conv_high, conv_low,
   output logic [3:0]      conv_channel
);
   assign fault_event = (fire && code[5:3] == 3'h0) ? 8'h01 << code[2:0] : 8'h00;
   assign enable_pin_changed = fire && code == 6'h08;
   assign nvm_written = fire && code == 6'h09;
   assign conv_done = fire && code[5];
   assign conv_high = conv_done && !code[4];
   assign conv_low = conv_done && code[4];
   // Off a conversion the channel lines carry the inverted code, which can still name a valid channel.
   assign conv_channel = conv_done ? code[3:0] : ~code[3:0];
endmodule : mac_src
`default_nettype wire

//--- verification/mac_regs_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module mac_regs_chk (
   input wire logic       clk, sys_rst, reg_wr, reg_rd, reg_rvalid, alert_clear, alert_generated,
   input wire logic       enable_pin_changed, nvm_written, conv_done,
   input wire logic [7:0] reg_addr, reg_wdata, reg_rdata, sel_single_ended, sel_pair_sense, fault_event,
   input wire logic [3:0] aux_io_pin_out, aux_io_pin_oe_n
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   sequence s_wr(logic [7:0] a); reg_wr && reg_addr == a; endsequence
   sequence s_quiet; fault_event == 8'h00 && !enable_pin_changed && !nvm_written && !conv_done; endsequence
   a_dir_to_oe: assert property (s_wr(8'h12) |=> aux_io_pin_oe_n == $past(reg_wdata[7:4])) else $error("oe");
   a_out_masked: assert property (s_wr(8'h12) |=>
      aux_io_pin_out == ($past(reg_wdata[3:0]) & ~$past(reg_wdata[7:4]))) else $error("out");
   a_sel_a_copy: assert property (s_wr(8'h13) |=> sel_single_ended == $past(reg_wdata)) else $error("sel a");
   a_sel_b_copy: assert property (s_wr(8'h14) |=> sel_pair_sense == $past(reg_wdata)) else $error("sel b");
   a_unmapped_zero: assert property (reg_rd && (reg_addr < 8'h12 || reg_addr > 8'h18) |=>
      reg_rvalid && reg_rdata == 8'h00) else $error("unmapped");
   a_rdata_stands: assert property (!reg_rd |=> !reg_rvalid && $stable(reg_rdata)) else $error("rdata");
   a_alert_latched: assert property (alert_generated && !alert_clear |=> alert_generated) else $error("held");
   a_no_cause: assert property ((s_quiet ##0 !alert_generated) |=> !alert_generated) else $error("spurious");
endmodule : mac_regs_chk
bind mac_regs mac_regs_chk chk (.*);
`default_nettype wire

//--- verification/mac_regs_bench.sv
`timescale 1ns/1ps
`default_nettype none
module mac_regs_bench;
   logic clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, alert_clear = 1'b0, fire = 1'b0;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, sel_single_ended, sel_pair_sense, fault_event;
   logic [5:0] code = 6'h00;
   logic [3:0] aux_io_pin_out, aux_io_pin_oe_n, conv_channel;
   logic       reg_rvalid, enable_pin_changed, nvm_written, conv_done, conv_high, conv_low, alert_generated;
   logic [7:0] rst_val [8] = '{8'hf0, 8'hff, 8'h0f, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
   int         n_errors = 0, tests_run = 0;
   always #5 clk = ~clk;
   mac_regs uut (.aux_io_pin_in(4'h5), .*);
   mac_src src (.*);
   task automatic chk(input logic [8:0] g, e);
      tests_run++;
      if (g !== e) begin
         n_errors++;
         $display("unexpected at %0t: got %h, expected %h", $time, g, e);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, d);
      @(posedge clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
      @(posedge clk) reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, e);
      @(posedge clk) {reg_rd, reg_addr} <= {1'b1, a};
      @(posedge clk) reg_rd <= 1'b0;
      // The read valid flag stands for the single cycle after the sampling edge; the data holds until the next read.
      #1 chk({reg_rvalid, reg_rdata}, {1'b1, e});
   endtask : rd
   task automatic ev(input logic [5:0] c, input logic e);
      @(posedge clk) {fire, code} <= {1'b1, c};
      @(posedge clk) fire <= 1'b0;
      #1 chk({8'h00, alert_generated}, {8'h00, e});
      @(posedge clk) alert_clear <= 1'b1;
      @(posedge clk) alert_clear <= 1'b0;
      #1 chk({8'h00, alert_generated}, 9'h000);
   endtask : ev
   task automatic close_out;
      if (n_errors == 0 && tests_run > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : close_out
   initial begin
      repeat (16) @(posedge clk);
      sys_rst <= 1'b0;
      for (int i = 0; i < 8; i++) rd(8'h12 + 8'(i), rst_val[i]);
      for (int j = 0; j < 10; j++) begin
         wr(j < 8 ? 8'h15 : 8'h16, j < 8 ? 8'h01 << j : 8'h80 >> (j - 8));
         ev(6'(j), 1'b1);
         ev(6'(j ^ 1), 1'b0);
      end
      for (int k = 0; k < 22; k++) begin
         wr(k < 8 ? 8'h17 : k < 16 ? 8'h18 : 8'h16, 8'h80 >> (k % 2 + k / 2 % 4 * 2 + (k > 15 ? 2 : 0)));
         ev(6'(32 + k % 2 * 16 + k / 2), 1'b1);
         ev(6'(32 + (k + 1) % 2 * 16 + k / 2), 1'b0);
      end
      wr(8'h13, 8'hfe);
      wr(8'h17, 8'h80);
      ev(6'h20, 1'b0);
      for (int i = 0; i < 8; i++) wr(8'h12 + 8'(i), 8'h3a + 8'(i * 17));
      for (int i = 0; i < 8; i++) rd(8'h12 + 8'(i), i < 7 ? 8'h3a + 8'(i * 17) : 8'h00);
      chk({1'b0, aux_io_pin_oe_n, aux_io_pin_out}, 9'h038);
      chk({1'b0, sel_single_ended}, 9'h04b);
      chk({1'b0, sel_pair_sense}, 9'h05c);
      sys_rst <= 1'b1;
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      rd(8'h12, 8'hf0);
      chk({1'b0, sel_pair_sense}, 9'h00f);
      close_out;
   end
endmodule : mac_regs_bench
`default_nettype wire
